/* pie_irq_bank.sv */
// The APB register port and the register offsets were left to the implementer.
`include "pie_params.svh"

module pie_irq_bank (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flags of other sources gated by the enable register
  input  wire logic [3:0]  logic_cell_irq_flag,
  input  wire logic        timer_gate_irq_flag,
  // enables of the capture/compare flags, held elsewhere
  input  wire logic [1:0]  capcomp_irq_enable,
  // capture/compare unit one events
  input  wire logic        capcomp_one_capture,
  input  wire logic        capcomp_one_match,
  input  wire logic        capcomp_one_trail,
  // capture/compare unit two events
  input  wire logic        capcomp_two_capture,
  input  wire logic        capcomp_two_match,
  input  wire logic        capcomp_two_trail,
  // requests toward the core
  output logic             peripheral_irq_req,
  output logic             core_irq_req,
  // register views for neighbouring logic
  output logic [3:0]       logic_cell_irq_enable,
  output logic             timer_gate_irq_enable,
  output logic             capcomp_two_irq_flag,
  output logic             capcomp_one_irq_flag,
  // summary interrupt of the event status register
  output logic             irq
);

  import pie_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // bus decode

  function automatic logic sel_is(input logic [11:0] addr,
                                  input logic [11:0] ofs);
    sel_is = (addr == ofs);
  endfunction

  // pick the event that sets a unit's flag for its current mode
  function automatic logic cc_event(input pie_cc_mode_t mode,
                                    input logic cap,
                                    input logic cmp,
                                    input logic trail);
    logic ev;
    ev = 1'b0;
    unique case (mode)
      PIE_CC_OFF:     ev = 1'b0;
      PIE_CC_CAPTURE: ev = cap;
      PIE_CC_COMPARE: ev = cmp;
      PIE_CC_PWM:     ev = trail;
    endcase
    cc_event = ev;
  endfunction

  logic       acc;
  logic       setup;
  logic       wr;
  logic       lane0;
  logic       hit_en;
  logic       hit_fl;
  logic       hit_gc;
  logic       hit_st;
  logic       hit_mk;
  logic       hit_md;
  logic       hit_rq;
  logic       mapped;
  pie_byte_t  wbyte;

  assign acc    = psel & penable;
  assign setup  = psel & ~penable;
  assign lane0  = pstrb[0];
  assign wr     = acc & pwrite & lane0;
  assign wbyte  = pwdata[7:0];

  assign hit_en = sel_is(paddr, `PIE_OFS_ENABLE_FIVE);
  assign hit_fl = sel_is(paddr, `PIE_OFS_FLAG_SIX);
  assign hit_gc = sel_is(paddr, `PIE_OFS_GLOBAL_CTRL);
  assign hit_st = sel_is(paddr, `PIE_OFS_EVT_STATUS);
  assign hit_mk = sel_is(paddr, `PIE_OFS_EVT_MASK);
  assign hit_md = sel_is(paddr, `PIE_OFS_CC_MODE);
  assign hit_rq = sel_is(paddr, `PIE_OFS_REQ_STATUS);
  assign mapped = hit_en | hit_fl | hit_gc | hit_st | hit_mk | hit_md | hit_rq;

  // zero wait states; read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  //////////////////////////////////////////////////////////////////////
  // enable, global control and mode registers

  pie_byte_t   enable_q;
  pie_byte_t   enable_d;
  logic [1:0]  gctrl_q;
  logic [1:0]  gctrl_d;
  logic [3:0]  mode_q;
  logic [3:0]  mode_d;
  logic [`PIE_EV_WIDTH-1:0] mask_q;
  logic [`PIE_EV_WIDTH-1:0] mask_d;

  always_comb begin
    enable_d = enable_q;
    gctrl_d  = gctrl_q;
    mode_d   = mode_q;
    mask_d   = mask_q;
    if (wr && hit_en) begin
      // unimplemented positions are never stored
      enable_d = wbyte & `PIE_EN_IMPL_MASK;
    end
    if (wr && hit_gc) begin
      gctrl_d = wbyte[1:0];
    end
    if (wr && hit_md) begin
      mode_d = wbyte[3:0];
    end
    if (wr && hit_mk) begin
      mask_d = wbyte[`PIE_EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= `PIE_RST_ENABLE_FIVE;
      gctrl_q  <= `PIE_RST_GLOBAL_CTRL;
      mode_q   <= `PIE_RST_CC_MODE;
      mask_q   <= `PIE_RST_EVT;
    end else begin
      enable_q <= enable_d;
      gctrl_q  <= gctrl_d;
      mode_q   <= mode_d;
      mask_q   <= mask_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // capture/compare flags

  pie_cc_mode_t mode_one;
  pie_cc_mode_t mode_two;
  logic [1:0]   cc_set;
  logic [1:0]   cc_flag;
  logic         fl_write;

  assign mode_one = pie_cc_mode_t'(mode_q[`PIE_MD_CC1_LSB +: 2]);
  assign mode_two = pie_cc_mode_t'(mode_q[`PIE_MD_CC2_LSB +: 2]);

  // flags follow their event alone, never any enable
  assign cc_set[`PIE_FL_CC1_BIT] = cc_event(mode_one, capcomp_one_capture,
                                            capcomp_one_match,
                                            capcomp_one_trail);
  assign cc_set[`PIE_FL_CC2_BIT] = cc_event(mode_two, capcomp_two_capture,
                                            capcomp_two_match,
                                            capcomp_two_trail);

  assign fl_write = wr & hit_fl;

  // writing 1 sets a flag as the core may; writing 0 is the only clear
  for (genvar i = 0; i < 2; i++) begin : g_cc
    pie_flag_cell u_flag (
      .clk      (clk),
      .rst_n    (rst_n),
      .hw_set   (cc_set[i]),
      .sw_write (fl_write),
      .sw_value (wbyte[i]),
      .flag     (cc_flag[i])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // request toward the core

  logic any_req;
  logic preq_q;
  logic preq_d;
  logic creq_q;
  logic creq_d;

  // a request lasts as long as flag, enable and the global control bits gating it all stay set
  assign any_req =
      (|(logic_cell_irq_flag & enable_q[`PIE_EN_LC_MSB:`PIE_EN_LC_LSB]))
    | (timer_gate_irq_flag & enable_q[`PIE_EN_TG_BIT])
    | (|(cc_flag & capcomp_irq_enable));

  always_comb begin
    preq_d = any_req & gctrl_q[`PIE_GC_PERIPH_BIT];
    creq_d = preq_d & gctrl_q[`PIE_GC_GLOBAL_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preq_q <= 1'b0;
      creq_q <= 1'b0;
    end else begin
      preq_q <= preq_d;
      creq_q <= creq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // event status, write one to clear

  logic [`PIE_EV_WIDTH-1:0] ev_set;
  logic [`PIE_EV_WIDTH-1:0] ev_stat;
  logic                     st_write;

  assign ev_set[`PIE_EV_CC1_BIT] = cc_set[`PIE_FL_CC1_BIT];
  assign ev_set[`PIE_EV_CC2_BIT] = cc_set[`PIE_FL_CC2_BIT];
  assign ev_set[`PIE_EV_REQ_BIT] = preq_d & ~preq_q;
  assign st_write = wr & hit_st;

  for (genvar j = 0; j < `PIE_EV_WIDTH; j++) begin : g_ev
    pie_flag_cell u_stat (
      .clk      (clk),
      .rst_n    (rst_n),
      .hw_set   (ev_set[j]),
      .sw_write (st_write & wbyte[j]),
      .sw_value (1'b0),
      .flag     (ev_stat[j])
    );
  end

  logic irq_q;
  logic irq_d;

  always_comb begin
    irq_d = |(ev_stat & mask_q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read path

  pie_byte_t rbyte;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // reserved bits come out as zero by construction
  always_comb begin
    rbyte = 8'h00;
    unique case (1'b1)
      hit_en:  rbyte = enable_q & `PIE_EN_IMPL_MASK;
      hit_fl:  rbyte = {6'h00, cc_flag};
      hit_gc:  rbyte = {6'h00, gctrl_q};
      hit_st:  rbyte = {5'h00, ev_stat};
      hit_mk:  rbyte = {5'h00, mask_q};
      hit_md:  rbyte = {4'h0, mode_q};
      hit_rq:  rbyte = {6'h00, creq_q, preq_q};
      default: rbyte = 8'h00;
    endcase
  end

  always_comb begin
    prdata_d = prdata_q;
    if (setup && !pwrite) begin
      prdata_d = {24'h000000, rbyte};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata                = prdata_q;
  assign peripheral_irq_req    = preq_q;
  assign core_irq_req          = creq_q;
  assign logic_cell_irq_enable = enable_q[`PIE_EN_LC_MSB:`PIE_EN_LC_LSB];
  assign timer_gate_irq_enable = enable_q[`PIE_EN_TG_BIT];
  assign capcomp_one_irq_flag  = cc_flag[`PIE_FL_CC1_BIT];
  assign capcomp_two_irq_flag  = cc_flag[`PIE_FL_CC2_BIT];
  assign irq                   = irq_q;

endmodule

/* pie_params.svh */
`ifndef PIE_PARAMS_SVH
`define PIE_PARAMS_SVH

// register byte offsets on the APB side
`define PIE_OFS_ENABLE_FIVE  12'h000
`define PIE_OFS_FLAG_SIX     12'h004
`define PIE_OFS_GLOBAL_CTRL  12'h008
`define PIE_OFS_EVT_STATUS   12'h00C
`define PIE_OFS_EVT_MASK     12'h010
`define PIE_OFS_CC_MODE      12'h014
`define PIE_OFS_REQ_STATUS   12'h018

// enable register fields
`define PIE_EN_LC_LSB        4
`define PIE_EN_LC_MSB        7
`define PIE_EN_TG_BIT        0
`define PIE_EN_IMPL_MASK     8'hF1

// flag register fields
`define PIE_FL_CC1_BIT       0
`define PIE_FL_CC2_BIT       1
`define PIE_FL_IMPL_MASK     8'h03

// global control fields
`define PIE_GC_PERIPH_BIT    0
`define PIE_GC_GLOBAL_BIT    1

// event status and mask fields
`define PIE_EV_CC1_BIT       0
`define PIE_EV_CC2_BIT       1
`define PIE_EV_REQ_BIT       2
`define PIE_EV_WIDTH         3

// capture/compare mode register fields
`define PIE_MD_CC1_LSB       0
`define PIE_MD_CC2_LSB       2

// reset values
`define PIE_RST_ENABLE_FIVE  8'h00
`define PIE_RST_FLAG_SIX     8'h00
`define PIE_RST_GLOBAL_CTRL  2'h0
`define PIE_RST_EVT          3'h0
`define PIE_RST_CC_MODE      4'h0

`endif

/* pie_pkg.sv */
package pie_pkg;

  // mode of one capture/compare unit; decides which event sets its flag
  typedef enum logic [1:0] {
    PIE_CC_OFF     = 2'b00,
    PIE_CC_CAPTURE = 2'b01,
    PIE_CC_COMPARE = 2'b10,
    PIE_CC_PWM     = 2'b11
  } pie_cc_mode_t;

  typedef logic [7:0] pie_byte_t;

endpackage

/* pie_flag_cell.sv */
module pie_flag_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // hardware side
  input  wire logic hw_set,
  // software side
  input  wire logic sw_write,
  input  wire logic sw_value,
  // state
  output logic      flag
);

  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (sw_write) begin
      flag_d = sw_value;
    end
    // a set arriving with a clear is kept
    if (hw_set) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule

/* pie_evt_src.sv */
module pie_evt_src (
  // clock and request from the bench
  input  wire logic       clk,
  input  wire logic [5:0] fire,
  // event strobes, unit one low, unit two high
  output logic [5:0]      evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // a strobe copies fire one edge later and lasts as long as fire, so a one-cycle request is one event
  always_ff @(posedge clk) evt <= fire;
endmodule

/* pie_irq_bank_chk.sv */
`include "pie_params.svh"
module pie_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // sources
  input wire logic [3:0]  logic_cell_irq_flag,
  input wire logic        timer_gate_irq_flag,
  input wire logic [1:0]  capcomp_irq_enable,
  input wire logic        capcomp_one_capture,
  input wire logic        capcomp_one_match,
  input wire logic        capcomp_one_trail,
  input wire logic        capcomp_two_capture,
  input wire logic        capcomp_two_match,
  input wire logic        capcomp_two_trail,
  // outputs
  input wire logic        peripheral_irq_req,
  input wire logic        core_irq_req,
  input wire logic [3:0]  logic_cell_irq_enable,
  input wire logic        timer_gate_irq_enable,
  input wire logic        capcomp_two_irq_flag,
  input wire logic        capcomp_one_irq_flag
);
  logic acc, wr, ev1, ev2, any;
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign ev1 = capcomp_one_capture || capcomp_one_match || capcomp_one_trail;
  assign ev2 = capcomp_two_capture || capcomp_two_match || capcomp_two_trail;
  assign any = (capcomp_one_irq_flag && capcomp_irq_enable[0])
    || (capcomp_two_irq_flag && capcomp_irq_enable[1])
    || (|(logic_cell_irq_flag & logic_cell_irq_enable))
    || (timer_gate_irq_flag && timer_gate_irq_enable);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  property p_lc; $past(wr && paddr == `PIE_OFS_ENABLE_FIVE) |->
    logic_cell_irq_enable == $past(pwdata[7:4]); endproperty
  a_lc: assert property (p_lc) else $error("cell enables not written");
  property p_tg; $past(wr && paddr == `PIE_OFS_ENABLE_FIVE) |->
    timer_gate_irq_enable == $past(pwdata[0]); endproperty
  a_tg: assert property (p_tg) else $error("timer enable not written");
  property p_hold; !$stable(logic_cell_irq_enable) |->
    $past(wr && paddr == `PIE_OFS_ENABLE_FIVE); endproperty
  a_hold: assert property (p_hold) else $error("enable moved alone");
  property p_rs_en; acc && !pwrite && paddr == `PIE_OFS_ENABLE_FIVE |->
    prdata[31:1] == {24'h0, prdata[7:4], 3'h0}; endproperty
  a_rs_en: assert property (p_rs_en) else $error("enable spare bits set");
  property p_rs_fl; acc && !pwrite && paddr == `PIE_OFS_FLAG_SIX |->
    prdata[31:2] == 30'h0; endproperty
  a_rs_fl: assert property (p_rs_fl) else $error("flag spare bits set");
  property p_set1; $rose(capcomp_one_irq_flag) |->
    $past(ev1 || (wr && paddr == `PIE_OFS_FLAG_SIX && pwdata[0])); endproperty
  a_set1: assert property (p_set1) else $error("flag one set without cause");
  property p_set2; $rose(capcomp_two_irq_flag) |->
    $past(ev2 || (wr && paddr == `PIE_OFS_FLAG_SIX && pwdata[1])); endproperty
  a_set2: assert property (p_set2) else $error("flag two set without cause");
  property p_clr1; $fell(capcomp_one_irq_flag) |->
    $past(wr && paddr == `PIE_OFS_FLAG_SIX && !pwdata[0]); endproperty
  a_clr1: assert property (p_clr1) else $error("flag one lost");
  property p_clr2; $fell(capcomp_two_irq_flag) |->
    $past(wr && paddr == `PIE_OFS_FLAG_SIX && !pwdata[1]); endproperty
  a_clr2: assert property (p_clr2) else $error("flag two lost");
  property p_req; peripheral_irq_req |-> $past(any); endproperty
  a_req: assert property (p_req) else $error("request without enabled flag");
  property p_core; core_irq_req |-> peripheral_irq_req; endproperty
  a_core: assert property (p_core) else $error("core request alone");
  cover property (peripheral_irq_req);
  cover property ($rose(capcomp_one_irq_flag));
  cover property ($fell(capcomp_two_irq_flag));
endmodule

/* pie_irq_bank_test.sv */
`include "pie_params.svh"
module pie_irq_bank_test;
  import pie_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, tg_f = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, d;
  logic [3:0]  pstrb = 4'hF, lc_f = 0, lc_en;
  logic [1:0]  cc_en = 0;
  logic [5:0]  fire = 0, evt;
  logic [2:0]  hit;
  logic        pready, pslverr, preq, creq, tg_en, f1, f2, irq;
  logic [32:0] exp_q[$];
  int          err_total = 0, comparisons = 0, n;
  always #20 clk = ~clk;
  pie_irq_bank i_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .logic_cell_irq_flag(lc_f),
    .timer_gate_irq_flag(tg_f), .capcomp_irq_enable(cc_en), .capcomp_one_capture(evt[0]),
    .capcomp_one_match(evt[1]), .capcomp_one_trail(evt[2]), .capcomp_two_capture(evt[3]),
    .capcomp_two_match(evt[4]), .capcomp_two_trail(evt[5]), .peripheral_irq_req(preq),
    .core_irq_req(creq), .logic_cell_irq_enable(lc_en), .timer_gate_irq_enable(tg_en),
    .capcomp_two_irq_flag(f2), .capcomp_one_irq_flag(f1), .irq(irq));
  pie_evt_src i_src (.clk(clk), .fire(fire), .evt(evt));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reads leave {pslverr, prdata} as a note for the monitor
  task automatic apb(input logic wr, input logic [11:0] a, input logic [32:0] v);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v[31:0];
    if (!wr) exp_q.push_back(v);
    @(posedge clk);
    penable <= 1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(input logic [5:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 0;
  endtask
  always @(posedge clk)
    if (psel && penable && !pwrite && pready === 1'b1)
      chk({pslverr, prdata}, exp_q.pop_front());
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(73));
    repeat (5) @(posedge clk);
    rst_n <= 1;
    apb(0, `PIE_OFS_ENABLE_FIVE, 0);
    apb(0, `PIE_OFS_FLAG_SIX, 0);
    apb(0, 12'h01C, 33'h100000000);
    $display("test reset done");
    repeat (4) begin
      d = $urandom;
      apb(1, `PIE_OFS_ENABLE_FIVE, d);
      apb(0, `PIE_OFS_ENABLE_FIVE, d & 32'hF1);
      chk(33'({lc_en, tg_en}), 33'({d[7:4], d[0]}));
    end
    pstrb <= 4'h0;
    apb(1, `PIE_OFS_ENABLE_FIVE, ~d);
    pstrb <= 4'hF;
    apb(0, `PIE_OFS_ENABLE_FIVE, d & 32'hF1);
    apb(1, `PIE_OFS_ENABLE_FIVE, 0);
    $display("test enable done");
    apb(1, `PIE_OFS_FLAG_SIX, 32'hFF);
    apb(0, `PIE_OFS_FLAG_SIX, 32'h3);
    apb(1, `PIE_OFS_FLAG_SIX, 0);
    apb(0, `PIE_OFS_FLAG_SIX, 0);
    $display("test flags done");
    // all enables stay off here, flags must still set
    for (int m = 0; m < 4; m++) begin
      apb(1, `PIE_OFS_CC_MODE, {28'h0, m[1:0], m[1:0]});
      hit = (m == 0) ? 3'b000 : 3'b001 << (m - 1);
      pulse({2{~hit}});
      apb(0, `PIE_OFS_FLAG_SIX, 0);
      pulse({2{hit}});
      repeat (8) @(posedge clk);
      apb(0, `PIE_OFS_FLAG_SIX, (m == 0) ? 0 : 3);
      apb(1, `PIE_OFS_FLAG_SIX, 0);
    end
    $display("test modes done");
    apb(1, `PIE_OFS_CC_MODE, {28'h0, PIE_CC_CAPTURE, PIE_CC_CAPTURE});
    apb(1, `PIE_OFS_GLOBAL_CTRL, 32'h3);
    apb(1, `PIE_OFS_EVT_MASK, 32'h7);
    cc_en <= 2'b10;
    pulse(6'b001001);
    // request register follows the event by two edges
    repeat (2) @(posedge clk);
    apb(0, `PIE_OFS_REQ_STATUS, 32'h3);
    apb(1, `PIE_OFS_FLAG_SIX, 32'h1);
    apb(0, `PIE_OFS_REQ_STATUS, 0);
    lc_f <= 4'h1;
    apb(1, `PIE_OFS_ENABLE_FIVE, 32'h10);
    apb(0, `PIE_OFS_REQ_STATUS, 32'h3);
    tg_f <= 1'b1;
    apb(1, `PIE_OFS_ENABLE_FIVE, 32'h01);
    apb(0, `PIE_OFS_REQ_STATUS, 32'h3);
    apb(1, `PIE_OFS_GLOBAL_CTRL, 32'h1);
    apb(0, `PIE_OFS_REQ_STATUS, 32'h1);
    apb(1, `PIE_OFS_GLOBAL_CTRL, 32'h2);
    apb(0, `PIE_OFS_REQ_STATUS, 0);
    apb(0, `PIE_OFS_EVT_STATUS, 32'h7);
    chk(33'(irq), 33'h1);
    apb(1, `PIE_OFS_EVT_STATUS, 32'h7);
    apb(0, `PIE_OFS_EVT_STATUS, 0);
    chk(33'(irq), 33'h0);
    $display("test requests done");
    // second reset in mid-run with enables and flag one set
    apb(1, `PIE_OFS_ENABLE_FIVE, 32'hF1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, `PIE_OFS_ENABLE_FIVE, 0);
    apb(0, `PIE_OFS_FLAG_SIX, 0);
    $display("test second reset done");
    end_sim();
  end
endmodule
bind pie_irq_bank pie_chk i_chk (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .logic_cell_irq_flag(logic_cell_irq_flag), .timer_gate_irq_flag(timer_gate_irq_flag),
  .capcomp_irq_enable(capcomp_irq_enable), .capcomp_one_capture(capcomp_one_capture),
  .capcomp_one_match(capcomp_one_match), .capcomp_one_trail(capcomp_one_trail),
  .capcomp_two_capture(capcomp_two_capture), .capcomp_two_match(capcomp_two_match),
  .capcomp_two_trail(capcomp_two_trail), .peripheral_irq_req(peripheral_irq_req),
  .core_irq_req(core_irq_req), .logic_cell_irq_enable(logic_cell_irq_enable),
  .timer_gate_irq_enable(timer_gate_irq_enable),
  .capcomp_two_irq_flag(capcomp_two_irq_flag), .capcomp_one_irq_flag(capcomp_one_irq_flag));
